// ===== hw/scbr_top.sv
// serial channel 2 baud generator, data pin routing and stop-mode control
`timescale 1ns/1ns
module scbr_top
  import scbr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        osc_half_select,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  input  wire logic        primary_rx_pin,
  input  wire logic        alternate_rx_pin,
  input  wire logic        ext_baud_clock_pin,
  input  wire logic        core_txd,
  output logic             core_rxd,
  output logic             primary_tx_pin,
  output logic             primary_tx_oe,
  output logic             alternate_tx_pin,
  output logic             alternate_tx_oe,
  output logic             serial_pins_owned,
  output logic             baud_tick,
  output scbr_mode_e       chan_mode
);
  import scbr_pkg::*;

  logic [7:0]            async_mode_reg;
  logic [7:0]            sync_serial_mode;
  logic [7:0]            baud_gen_control;
  logic [7:0]            serial_pin_route;
  logic [1:0]            rx_p_sync;
  logic [1:0]            rx_a_sync;
  logic [2:0]            ext_sync;
  logic [PRESCALE_W-1:0] pre_cnt;
  logic [PRESCALE_W-1:0] pre_mask;
  logic [3:0]            n_sel;
  logic                  pre_tick;
  logic                  ext_edge;
  logic                  src_tick;
  logic                  gen_run;
  logic                  div_tick;
  logic                  ext_div_tick;
  logic                  active;
  logic                  osc_phase;
  logic                  fxx_tick;
  scbr_mode_e            next_mode;
  logic [3:0]            k_val;
  logic [3:0]            tps_val;

  assign k_val   = baud_gen_control[DIV_LSB +: 4];
  assign tps_val = baud_gen_control[PRESCALE_LSB +: 4];

  // register writes; reserved bits are held at zero regardless of software
  always_ff @(posedge clk) begin
    if (rst) begin
      async_mode_reg   <= REG_RESET;
      sync_serial_mode <= REG_RESET;
      baud_gen_control <= REG_RESET;
      serial_pin_route <= REG_RESET;
    end else if (ce && mem_wr) begin
      case (mem_addr)
        ASYNC_MODE_ADDR: async_mode_reg   <= mem_wdata;
        SYNC_MODE_ADDR:  sync_serial_mode <= mem_wdata & SYNC_MODE_WMASK;
        BAUD_CTRL_ADDR:  baud_gen_control <= mem_wdata;
        PIN_ROUTE_ADDR:  serial_pin_route <= mem_wdata & PIN_ROUTE_WMASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rdata <= 8'h00;
    end else if (ce && mem_rd) begin
      case (mem_addr)
        ASYNC_MODE_ADDR: mem_rdata <= async_mode_reg;
        SYNC_MODE_ADDR:  mem_rdata <= sync_serial_mode;
        BAUD_CTRL_ADDR:  mem_rdata <= baud_gen_control;
        PIN_ROUTE_ADDR:  mem_rdata <= serial_pin_route;
        default:         mem_rdata <= 8'h00;
      endcase
    end
  end

  // mode decode: three-wire wins when both sides are enabled
  always_comb begin
    if (sync_serial_mode[THREE_WIRE_EN_BIT]) begin
      next_mode = SCBR_THREE_WIRE;
    end else if (async_mode_reg[TX_EN_BIT] || async_mode_reg[RX_EN_BIT]) begin
      next_mode = SCBR_ASYNC;
    end else begin
      next_mode = SCBR_STOP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chan_mode <= SCBR_STOP;
    end else if (ce) begin
      chan_mode <= next_mode;
    end
  end

  assign active = (next_mode != SCBR_STOP);

  // pin inputs pass two flip-flops; ext clock gets a third stage for edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_p_sync <= 2'b11;
      rx_a_sync <= 2'b11;
      ext_sync  <= 3'b000;
    end else if (ce) begin
      rx_p_sync <= {rx_p_sync[0], primary_rx_pin};
      rx_a_sync <= {rx_a_sync[0], alternate_rx_pin};
      ext_sync  <= {ext_sync[1:0], ext_baud_clock_pin};
    end
  end
  assign ext_edge = ext_sync[1] & ~ext_sync[2];

  // fxx: every clk, or every other clk when half select is set
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_phase <= 1'b0;
    end else if (ce) begin
      osc_phase <= ~osc_phase;
    end
  end
  assign fxx_tick = osc_half_select ? osc_phase : 1'b1;

  // prescale code to n; prohibited codes leave the generator idle
  always_comb begin
    if (tps_val == PRESCALE_N11_CODE) begin
      n_sel = PRESCALE_N_MAX;
    end else if (tps_val >= PRESCALE_MIN_CODE && tps_val <= PRESCALE_MAX_CODE) begin
      n_sel = tps_val - 4'h4;
    end else begin
      n_sel = 4'h0;
    end
  end

  // free-running prescaler; bit n-1 toggling marks fxx/2^n
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt <= '0;
    end else if (ce) begin
      if (!active) begin
        pre_cnt <= '0;
      end else if (fxx_tick) begin
        pre_cnt <= pre_cnt + PRESCALE_W'(1);
      end
    end
  end
  // n = 11 wraps the shift to zero, so the mask still covers all prescaler bits
  assign pre_mask = (PRESCALE_W'(1) << n_sel) - PRESCALE_W'(1);
  assign pre_tick = fxx_tick && (n_sel != 4'h0) && ((pre_cnt & pre_mask) == pre_mask);

  assign src_tick = pre_tick;
  assign gen_run  = active && (n_sel != 4'h0);

  scbr_divider u_int_div (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .run      (gen_run),
    .src_tick (src_tick),
    .k        (k_val),
    .out_tick (div_tick)
  );

  // external clock: rising edges give fpin, so half rate via k+16 then /2
  logic ext_half;
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_half <= 1'b0;
    end else if (ce && ext_div_tick) begin
      ext_half <= ~ext_half;
    end
  end

  scbr_divider u_ext_div (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .run      (active),
    .src_tick (ext_edge),
    .k        (k_val),
    .out_tick (ext_div_tick)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      baud_tick <= 1'b0;
    end else if (ce) begin
      if (!active) begin
        baud_tick <= 1'b0;
      // each mode takes its clock choice from its own register only
      end else if ((next_mode == SCBR_THREE_WIRE) ? sync_serial_mode[TW_CLK_SEL_BIT]
                                                   : async_mode_reg[ASYNC_CLK_SEL_BIT]) begin
        baud_tick <= div_tick;
      end else begin
        baud_tick <= ext_div_tick && ext_half;
      end
    end
  end

  // pin routing; stop mode releases every pin
  always_ff @(posedge clk) begin
    if (rst) begin
      core_rxd          <= 1'b1;
      primary_tx_pin    <= 1'b1;
      primary_tx_oe     <= 1'b0;
      alternate_tx_pin  <= 1'b1;
      alternate_tx_oe   <= 1'b0;
      serial_pins_owned <= 1'b0;
    end else if (ce) begin
      core_rxd <= serial_pin_route[RX_ALT_BIT] ? rx_a_sync[1] : rx_p_sync[1];
      primary_tx_pin    <= core_txd;
      alternate_tx_pin  <= core_txd;
      primary_tx_oe     <= active && !serial_pin_route[TX_ALT_BIT];
      alternate_tx_oe   <= active && serial_pin_route[TX_ALT_BIT];
      serial_pins_owned <= active;
    end
  end

  a_stop_release : assert property (@(posedge clk) disable iff (rst)
    (ce && !active) |=> (!primary_tx_oe && !alternate_tx_oe && !baud_tick))
    else $error("stop mode still drives pins or ticks");
  a_tx_route : assert property (@(posedge clk) disable iff (rst)
    (ce && active && serial_pin_route[TX_ALT_BIT]) |=> (alternate_tx_oe && !primary_tx_oe))
    else $error("transmit not routed to alternate pin");
  a_rx_route : assert property (@(posedge clk) disable iff (rst)
    (ce && serial_pin_route[RX_ALT_BIT]) |=> core_rxd == $past(rx_a_sync[1]))
    else $error("receive not taken from alternate pin");
  a_mode_decode : assert property (@(posedge clk) disable iff (rst)
    (ce && sync_serial_mode[THREE_WIRE_EN_BIT]) |=> chan_mode == SCBR_THREE_WIRE)
    else $error("three-wire enable not reflected in mode");
  a_reserved_zero : assert property (@(posedge clk) disable iff (rst)
    (sync_serial_mode & ~SYNC_MODE_WMASK) == 8'h00 && (serial_pin_route & ~PIN_ROUTE_WMASK) == 8'h00)
    else $error("reserved register bits became set");
  a_reset_clear : assert property (@(posedge clk)
    rst |=> (serial_pin_route == 8'h00 && sync_serial_mode == 8'h00))
    else $error("registers not cleared by reset");
  a_async_mode : assert property (@(posedge clk) disable iff (rst)
    (ce && !sync_serial_mode[THREE_WIRE_EN_BIT] && !async_mode_reg[TX_EN_BIT] &&
     !async_mode_reg[RX_EN_BIT]) |=> chan_mode == SCBR_STOP)
    else $error("enables clear but mode not stop");
  a_half_rate : assert property (@(posedge clk) disable iff (rst)
    (ce && osc_half_select && fxx_tick) |=> !(ce && osc_half_select && fxx_tick))
    else $error("half select produced back to back fxx");

  c_async_run  : cover property (@(posedge clk) chan_mode == SCBR_ASYNC && baud_tick);
  c_three_wire : cover property (@(posedge clk) chan_mode == SCBR_THREE_WIRE && baud_tick);
  c_alt_pins   : cover property (@(posedge clk) alternate_tx_oe && serial_pin_route[RX_ALT_BIT]);
endmodule : scbr_top

// ===== hw/scbr_pkg.sv
// shared constants for the serial channel 2 baud generator and pin router
package scbr_pkg;
  localparam logic [15:0] ASYNC_MODE_ADDR     = 16'hff70;
  localparam logic [15:0] SYNC_MODE_ADDR      = 16'hff72;
  localparam logic [15:0] BAUD_CTRL_ADDR      = 16'hff73;
  localparam logic [15:0] PIN_ROUTE_ADDR      = 16'hff75;
  localparam logic [7:0]  REG_RESET           = 8'h00;
  localparam logic [7:0]  SYNC_MODE_WMASK     = 8'h86;
  localparam logic [7:0]  PIN_ROUTE_WMASK     = 8'h30;
  localparam int          TX_EN_BIT           = 7;
  localparam int          RX_EN_BIT           = 6;
  localparam int          ASYNC_CLK_SEL_BIT   = 0;
  localparam int          THREE_WIRE_EN_BIT   = 7;
  localparam int          FIRST_BIT_ORDER_BIT = 2;
  localparam int          TW_CLK_SEL_BIT      = 1;
  localparam int          RX_ALT_BIT          = 4;
  localparam int          TX_ALT_BIT          = 5;
  localparam int          DIV_LSB             = 0;
  localparam int          PRESCALE_LSB        = 4;
  localparam logic [3:0]  DIV_BYPASS          = 4'hf;
  localparam logic [4:0]  DIV_BASE            = 5'h10;
  localparam logic [3:0]  PRESCALE_N11_CODE   = 4'h0;
  localparam logic [3:0]  PRESCALE_MIN_CODE   = 4'h5;
  localparam logic [3:0]  PRESCALE_MAX_CODE   = 4'he;
  localparam logic [3:0]  PRESCALE_N_MAX      = 4'hb;
  localparam int          PRESCALE_W          = 11;
  typedef enum logic [1:0] {SCBR_STOP, SCBR_ASYNC, SCBR_THREE_WIRE} scbr_mode_e;
endpackage : scbr_pkg

// ===== hw/scbr_divider.sv
// divide-by-(k+16) counter producing one-cycle ticks, bypass on code 1111
`timescale 1ns/1ns
module scbr_divider
  import scbr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       src_tick,
  input  wire logic [3:0] k,
  output logic            out_tick
);
  logic [4:0] cnt;
  logic [4:0] last;
  assign last = DIV_BASE + {1'b0, k} - 5'h01;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt      <= 5'h00;
      out_tick <= 1'b0;
    end else if (ce) begin
      out_tick <= 1'b0;
      if (!run) begin
        cnt <= 5'h00;
      end else if (src_tick) begin
        if (k == DIV_BYPASS) begin
          out_tick <= 1'b1;
        end else if (cnt >= last) begin
          cnt      <= 5'h00;
          out_tick <= 1'b1;
        end else begin
          cnt <= cnt + 5'h01;
        end
      end
    end
  end

  a_div_ratio : assert property (@(posedge clk) disable iff (rst)
    (ce && run && src_tick && k != DIV_BYPASS && cnt != last && cnt < last) |=> !out_tick)
    else $error("divider ticked before k+16 source edges");
  a_div_bypass : assert property (@(posedge clk) disable iff (rst)
    (ce && run && src_tick && k == DIV_BYPASS) |=> out_tick)
    else $error("bypass code did not pass source tick");
endmodule : scbr_divider

// ===== tb/scbr_remote.sv
// remote serial device with its optional external baud clock
`timescale 1ns/1ns
module scbr_remote (
  input  wire logic clk,
  input  wire logic ext_run,
  input  wire logic wired_alt,
  input  wire logic send_bit,
  input  wire logic primary_tx_pin,
  input  wire logic primary_tx_oe,
  input  wire logic alternate_tx_pin,
  input  wire logic alternate_tx_oe,
  output logic      ext_baud_clock_pin,
  output logic      primary_rx_pin,
  output logic      alternate_rx_pin,
  output logic      line_seen
);
  logic [1:0] div;
  initial begin
    div = 2'h0;
    ext_baud_clock_pin = 1'b0;
  end
  // clock stands still low while not running, 8 clk period otherwise
  always @(posedge clk) begin
    div <= div + 2'h1;
    if (!ext_run) ext_baud_clock_pin <= 1'b0;
    else if (div == 2'h3) ext_baud_clock_pin <= !ext_baud_clock_pin;
  end
  // the unwired pair floats to its pull-up, as does an undriven tx line
  assign primary_rx_pin   = wired_alt ? 1'b1 : send_bit;
  // the alternate pin carries serial data only, never an edge-detect function
  assign alternate_rx_pin = wired_alt ? send_bit : 1'b1;
  // the line is seen only while the chosen pin is set up as an output
  assign line_seen = wired_alt ? (alternate_tx_oe ? alternate_tx_pin : 1'b1)
                               : (primary_tx_oe ? primary_tx_pin : 1'b1);
endmodule : scbr_remote

// ===== tb/tb_top.sv
// self-checking bench for the channel 2 baud generator and pin router
`timescale 1ns/1ns
module tb_top;
  import scbr_pkg::*;
  logic clk = 0, rst = 1, ce = 1, osc_half_select = 0, mem_wr = 0, mem_rd = 0;
  logic [15:0] mem_addr = 16'h0000;
  logic [7:0]  mem_wdata = 8'h00, mem_rdata, rv;
  logic core_txd = 1, ext_run = 0, wired_alt = 0, send_bit = 1, line_seen, core_rxd;
  logic primary_rx_pin, alternate_rx_pin, ext_baud_clock_pin, serial_pins_owned, baud_tick;
  logic primary_tx_pin, primary_tx_oe, alternate_tx_pin, alternate_tx_oe;
  logic [15:0] n;
  scbr_mode_e  chan_mode;
  int bad_count = 0, samples_checked = 0;
  always #25 clk = !clk;
  scbr_top i_scbr_top (.clk(clk), .rst(rst), .ce(ce), .osc_half_select(osc_half_select),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .primary_rx_pin(primary_rx_pin), .alternate_rx_pin(alternate_rx_pin),
    .ext_baud_clock_pin(ext_baud_clock_pin), .core_txd(core_txd), .core_rxd(core_rxd),
    .primary_tx_pin(primary_tx_pin), .primary_tx_oe(primary_tx_oe),
    .alternate_tx_pin(alternate_tx_pin), .alternate_tx_oe(alternate_tx_oe),
    .serial_pins_owned(serial_pins_owned), .baud_tick(baud_tick), .chan_mode(chan_mode));
  scbr_remote i_scbr_remote (.clk(clk), .ext_run(ext_run), .wired_alt(wired_alt),
    .send_bit(send_bit), .primary_tx_pin(primary_tx_pin), .primary_tx_oe(primary_tx_oe),
    .alternate_tx_pin(alternate_tx_pin), .alternate_tx_oe(alternate_tx_oe),
    .ext_baud_clock_pin(ext_baud_clock_pin), .primary_rx_pin(primary_rx_pin),
    .alternate_rx_pin(alternate_rx_pin), .line_seen(line_seen));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge clk);
    mem_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    mem_addr <= a;
    mem_rd <= 1'b1;
    @(posedge clk);
    mem_rd <= 1'b0;
    @(negedge clk);
    rv = mem_rdata;
  endtask : rd
  // skips the first tick, whose phase depends on the write, then times one period
  task automatic measure;
    n = 16'h0000;
    @(negedge clk);
    while (baud_tick !== 1'b1 && n < 16'hf000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    n = 16'h0001;
    while (baud_tick !== 1'b1 && n < 16'hf000) begin
      @(negedge clk);
      n++;
    end
  endtask : measure
  task automatic t_regs;
    rd(SYNC_MODE_ADDR); chk(rv, 8'h00);
    rd(PIN_ROUTE_ADDR); chk(rv, 8'h00);
    chk(chan_mode, SCBR_STOP);
    chk({primary_tx_oe, alternate_tx_oe}, 2'h0);
    wr(SYNC_MODE_ADDR, 8'hfd); // reserved bits set on purpose, must read back clear
    rd(SYNC_MODE_ADDR); chk(rv, 8'h84);
    wr(SYNC_MODE_ADDR, 8'h00);
    wr(PIN_ROUTE_ADDR, 8'hff);
    rd(PIN_ROUTE_ADDR); chk(rv, 8'h30);
    wr(PIN_ROUTE_ADDR, 8'h00);
    wr(16'hff7f, 8'h5a);
    rd(16'hff7f); chk(rv, 8'h00);
  endtask : t_regs
  // writes made while the clock enable is low must be lost
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr(PIN_ROUTE_ADDR, 8'h30);
    wr(ASYNC_MODE_ADDR, 8'hc0);
    ce <= 1'b1;
    rd(PIN_ROUTE_ADDR); chk(rv, 8'h00);
    chk({chan_mode, serial_pins_owned}, {SCBR_STOP, 1'b0});
  endtask : t_freeze
  // code, k, half; period = 2^n * (k+16) clocks, doubled when fxx = fx/2
  task automatic t_internal;
    logic [8:0] tbl [5] = '{9'h050, 9'h05e, 9'h161, 9'h093, 9'h000};
    logic [15:0] e;
    foreach (tbl[i]) begin
      e = (16'h0001 << ((tbl[i][7:4] == 4'h0) ? 4'hb : tbl[i][7:4] - 4'h4));
      e = (e * ({12'h000, tbl[i][3:0]} + 16'h0010)) << tbl[i][8];
      @(posedge clk);
      osc_half_select <= tbl[i][8];
      wr(BAUD_CTRL_ADDR, tbl[i][7:0]);
      wr(ASYNC_MODE_ADDR, 8'hc1);
      measure;
      chk(n, e);
      wr(ASYNC_MODE_ADDR, 8'h00);
    end
  endtask : t_internal
  task automatic t_external;
    wr(BAUD_CTRL_ADDR, 8'h52);
    wr(ASYNC_MODE_ADDR, 8'hc0);
    @(posedge clk);
    ext_run <= 1'b1;
    measure;
    chk(n, 16'h0120);
    @(posedge clk);
    ext_run <= 1'b0;
    wr(ASYNC_MODE_ADDR, 8'h00);
  endtask : t_external
  task automatic t_bypass;
    wr(BAUD_CTRL_ADDR, 8'h5f);
    wr(SYNC_MODE_ADDR, 8'h82);
    measure;
    chk(n, 16'h0002);
    chk(chan_mode, SCBR_THREE_WIRE);
    wr(SYNC_MODE_ADDR, 8'h00);
  endtask : t_bypass
  task automatic t_route(input logic alt);
    wr(PIN_ROUTE_ADDR, {2'h0, alt, alt, 4'h0});
    @(posedge clk);
    wired_alt <= alt;
    send_bit <= 1'b0;
    core_txd <= 1'b0;
    wr(ASYNC_MODE_ADDR, 8'hc1);
    repeat (5) @(negedge clk);
    chk({chan_mode, serial_pins_owned}, {SCBR_ASYNC, 1'b1});
    chk({core_rxd, line_seen}, 2'h0);
    chk({primary_tx_oe, alternate_tx_oe}, {!alt, alt});
    @(posedge clk);
    send_bit <= 1'b1;
    core_txd <= 1'b1;
    repeat (5) @(negedge clk);
    chk({core_rxd, line_seen}, 2'h3);
    wr(ASYNC_MODE_ADDR, 8'h00);
    // the tick launched at the write edge still comes from the old mode
    @(posedge clk);
    n = 16'h0000;
    repeat (100) begin
      @(negedge clk);
      if (baud_tick !== 1'b0) n++;
    end
    chk(n, 16'h0000);
    chk({primary_tx_oe, alternate_tx_oe, serial_pins_owned}, 3'h0);
  endtask : t_route
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_freeze;
    t_bypass;
    t_external;
    t_route(1'b1);
    t_route(1'b0);
    t_internal;
    stop_test;
  end
endmodule : tb_top
